// ===== hw/flash_host_pkg.sv
// constants, types and helpers shared by the flash protection host
package flash_host_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min
   localparam int RST_HOLD_NS = 500;
   localparam int WAKE_NS = 200;
   localparam int WE_LOW_NS = 100;
   localparam int ACCESS_NS = 70;
   localparam int SYNC_CYC = 2;
   localparam logic [3:0] RST_CYC = 4'(cyc_min(RST_HOLD_NS));
   localparam logic [3:0] WAKE_CYC = 4'(cyc_min(WAKE_NS));
   localparam logic [3:0] WE_CYC = 4'(cyc_min(WE_LOW_NS));
   localparam logic [3:0] RD_CYC = 4'(cyc_min(ACCESS_NS) + SYNC_CYC);

   // ----------------------------------------------------------------
   // software register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] ADDR_OFS = 8'h08;
   localparam logic [7:0] WDATA_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   localparam logic [7:0] RDATA_OFS = 8'h14;
   localparam int CTRL_WP_BIT = 0;
   localparam int CTRL_ACCEL_BIT = 1;
   localparam int CTRL_TEMP_BIT = 2;
   localparam int CTRL_BYPASS_BIT = 3;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_REFUSED_BIT = 1;
   localparam int ST_REGION_BIT = 2;
   localparam int ST_READY_BIT = 3;
   localparam int ST_GROUP_LSB = 4;
   localparam int ST_OUTER_BIT = 9;
   localparam logic CTRL_WP_RST = 1'b0;

   // ----------------------------------------------------------------
   // flash command words (word mode)
   // ----------------------------------------------------------------
   localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
   localparam logic [19:0] UNLOCK2_ADDR = 20'h002AA;
   localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
   localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [15:0] PROG_DATA = 16'h00A0;
   localparam logic [15:0] ENTER_DATA = 16'h0088;
   localparam logic [15:0] EXIT_DATA = 16'h0090;
   localparam logic [15:0] EXIT2_DATA = 16'h0000;
   localparam logic [15:0] RESET_DATA = 16'h00F0;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_HWRST = 3'h1,
      OP_SWRST = 3'h2,
      OP_PROG = 3'h3,
      OP_ENTER = 3'h4,
      OP_EXIT = 3'h5,
      OP_READ = 3'h6
   } op_t;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_RST_LOW = 6'h02,
      S_WAKE = 6'h04,
      S_WR_LOW = 6'h08,
      S_WR_HIGH = 6'h10,
      S_RD = 6'h20
   } state_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] data;
      logic last;
   } bus_cyc_t;

   typedef struct packed {
      logic [19:0] addr;
      logic [15:0] dq_o;
      logic dq_oe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_n;
      logic reset_elevated;
      logic protect_accel_pin;
      logic accel_high;
   } pins_t;

   typedef struct packed {
      state_t st;
      logic [3:0] cnt;
      logic [1:0] idx;
      op_t op;
      logic wp_high;
      logic accel;
      logic temp;
      logic bypass;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [19:0] bus_addr;
      logic [15:0] bus_data;
      logic last;
      logic [15:0] rdata;
      logic refused;
      logic in_region;
      logic ready;
      logic [31:0] sw_rdata;
   } ctl_t;

   // protection group of a word address, bottom-boot layout
   function automatic logic [4:0] group_of(input logic [19:0] a);
      if (a[19:15] == 5'h00)
         return {2'h0, a[14:12]};
      else if (a[19:17] == 3'h0)
         return 5'h08;
      else if (a[19:17] != 3'h7)
         return 5'h08 + {2'h0, a[19:17]};
      else if (a[16:15] == 2'h3)
         return 5'h10;
      else
         return 5'h0F;
   endfunction : group_of

   // the two lowest blocks are the outermost boot blocks
   function automatic logic is_outermost(input logic [19:0] a);
      return group_of(a) < 5'h02;
   endfunction : is_outermost

   function automatic bus_cyc_t seq_cycle(input op_t op, input logic byp,
      input logic [1:0] idx, input logic [19:0] a, input logic [15:0] w);
      bus_cyc_t c;
      c.addr = UNLOCK1_ADDR;
      c.data = UNLOCK1_DATA;
      c.last = 1'b0;
      if (idx == 2'h1)
      begin
         c.addr = UNLOCK2_ADDR;
         c.data = UNLOCK2_DATA;
      end
      case (op)
         OP_SWRST:
         begin
            c.data = RESET_DATA;
            c.last = 1'b1;
         end
         OP_PROG:
         begin
            if ((byp && idx == 2'h0) || (!byp && idx == 2'h2))
            begin
               c.addr = UNLOCK1_ADDR;
               c.data = PROG_DATA;
            end
            else if ((byp && idx == 2'h1) || idx == 2'h3)
            begin
               c.addr = a;
               c.data = w;
               c.last = 1'b1;
            end
         end
         OP_ENTER:
         begin
            if (idx == 2'h2)
            begin
               c.data = ENTER_DATA;
               c.last = 1'b1;
            end
         end
         OP_EXIT:
         begin
            if (idx == 2'h2)
               c.data = EXIT_DATA;
            else if (idx == 2'h3)
            begin
               c.data = EXIT2_DATA;
               c.last = 1'b1;
            end
         end
         default: c.last = 1'b1;
      endcase
      return c;
   endfunction : seq_cycle

endpackage : flash_host_pkg

// ===== hw/pin_sync.sv
// two-flop synchroniser for the flash data pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] din,
   output logic [15:0] dout
);
   typedef struct packed {
      logic [15:0] meta;
      logic [15:0] held;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb
   begin
      d.meta = din;
      d.held = q.meta;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end

   assign dout = q.held;
endmodule : pin_sync
`default_nettype wire

// ===== hw/flash_protect_host.sv
// host controller driving the flash reset, protection and accelerate pins
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - accelerate level gives bypass; host uses two-cycle program until a CTRL write clears it
// - host holds reset pin low at least 500 ns
// - after reset rises, wait 200 ns before trusting read data
// - host holds reset low through power-up; device then reads
module flash_protect_host (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [15:0] dq_i,
   output flash_host_pkg::pins_t flash
);
   flash_host_pkg::ctl_t q;
   flash_host_pkg::ctl_t d;
   flash_host_pkg::bus_cyc_t nxt;
   flash_host_pkg::op_t new_op;
   logic [15:0] dq_sync;
   logic cmd_wr;
   logic byp;
   logic outer_lock;

   pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .din(dq_i),
      .dout(dq_sync)
   );

   assign cmd_wr = reg_wr && reg_addr == flash_host_pkg::CMD_OFS;
   assign new_op = flash_host_pkg::op_t'(reg_wdata[2:0]);
   // accelerate level implies the two-cycle program form
   assign byp = q.bypass | q.accel;
   // low protect pin with no accelerate locks the outer blocks, even when
   // the reset pin is elevated, so refuse here instead of being ignored
   assign outer_lock = !q.wp_high && !q.accel && !q.in_region
      && flash_host_pkg::is_outermost(q.addr);
   // the cycle after the current one, loaded on the way into S_WR_LOW
   assign nxt = flash_host_pkg::seq_cycle(q.op, byp, q.idx + 2'h1, q.addr, q.wdata);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.sw_rdata = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            flash_host_pkg::CTRL_OFS:
               d.sw_rdata = {28'h0, q.bypass, q.temp, q.accel, q.wp_high};
            flash_host_pkg::CMD_OFS:
               d.sw_rdata = {29'h0, q.op};
            flash_host_pkg::ADDR_OFS:
               d.sw_rdata = {12'h0, q.addr};
            flash_host_pkg::WDATA_OFS:
               d.sw_rdata = {16'h0, q.wdata};
            flash_host_pkg::STATUS_OFS:
               d.sw_rdata = {22'h0, flash_host_pkg::is_outermost(q.addr),
                  flash_host_pkg::group_of(q.addr), q.ready, q.in_region,
                  q.refused, q.st != flash_host_pkg::S_IDLE};
            flash_host_pkg::RDATA_OFS:
               d.sw_rdata = {16'h0, q.rdata};
            default: d.sw_rdata = '0;
         endcase
      end
      if (reg_wr)
      begin
         case (reg_addr)
            flash_host_pkg::CTRL_OFS:
            begin
               d.wp_high = reg_wdata[flash_host_pkg::CTRL_WP_BIT];
               d.accel = reg_wdata[flash_host_pkg::CTRL_ACCEL_BIT];
               d.temp = reg_wdata[flash_host_pkg::CTRL_TEMP_BIT];
               d.bypass = reg_wdata[flash_host_pkg::CTRL_BYPASS_BIT];
            end
            flash_host_pkg::ADDR_OFS: d.addr = reg_wdata[19:0];
            flash_host_pkg::WDATA_OFS: d.wdata = reg_wdata[15:0];
            flash_host_pkg::STATUS_OFS:
               if (reg_wdata[flash_host_pkg::ST_REFUSED_BIT])
                  d.refused = 1'b0;
            default: ;
         endcase
      end
      // set after the clear so a refusal in the same cycle is kept
      if (cmd_wr && q.st != flash_host_pkg::S_IDLE)
         d.refused = 1'b1;
      unique case (q.st)
         flash_host_pkg::S_RST_LOW:
         begin
            d.ready = 1'b0;
            d.in_region = 1'b0;
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == flash_host_pkg::RST_CYC - 4'h1)
            begin
               d.st = flash_host_pkg::S_WAKE;
               d.cnt = '0;
            end
         end
         flash_host_pkg::S_WAKE:
         begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == flash_host_pkg::WAKE_CYC - 4'h1)
            begin
               d.st = flash_host_pkg::S_IDLE;
               d.ready = 1'b1;
            end
         end
         flash_host_pkg::S_IDLE:
         begin
            if (cmd_wr)
            begin
               d.op = new_op;
               d.idx = '0;
               d.cnt = '0;
               case (new_op)
                  flash_host_pkg::OP_HWRST:
                     d.st = flash_host_pkg::S_RST_LOW;
                  flash_host_pkg::OP_READ:
                  begin
                     d.bus_addr = q.addr;
                     d.st = flash_host_pkg::S_RD;
                  end
                  flash_host_pkg::OP_SWRST,
                  flash_host_pkg::OP_ENTER,
                  flash_host_pkg::OP_EXIT:
                     d.st = flash_host_pkg::S_WR_HIGH;
                  flash_host_pkg::OP_PROG:
                     if (outer_lock)
                        d.refused = 1'b1;
                     else
                        d.st = flash_host_pkg::S_WR_HIGH;
                  default: d.refused = 1'b1;
               endcase
               // a zero last flag marks the empty slot before cycle 0
               d.last = 1'b0;
               d.idx = 2'h3;
            end
         end
         flash_host_pkg::S_WR_LOW:
         begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == flash_host_pkg::WE_CYC - 4'h1)
            begin
               d.st = flash_host_pkg::S_WR_HIGH;
               d.cnt = '0;
            end
         end
         flash_host_pkg::S_WR_HIGH:
         begin
            if (q.last)
            begin
               d.st = flash_host_pkg::S_IDLE;
               if (q.op == flash_host_pkg::OP_ENTER)
                  d.in_region = 1'b1;
               else if (q.op == flash_host_pkg::OP_EXIT)
                  d.in_region = 1'b0;
            end
            else
            begin
               d.idx = q.idx + 2'h1;
               d.st = flash_host_pkg::S_WR_LOW;
               d.cnt = '0;
            end
         end
         flash_host_pkg::S_RD:
         begin
            // access time plus the two sync flops before the word is trusted
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == flash_host_pkg::RD_CYC - 4'h1)
            begin
               d.rdata = dq_sync;
               d.st = flash_host_pkg::S_IDLE;
            end
         end
      endcase
      // load the bus cycle that S_WR_LOW is about to drive
      if (d.st == flash_host_pkg::S_WR_LOW && q.st == flash_host_pkg::S_WR_HIGH)
      begin
         d.bus_addr = nxt.addr;
         d.bus_data = nxt.data;
         d.last = nxt.last;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
         q.st <= flash_host_pkg::S_RST_LOW;
         q.op <= flash_host_pkg::OP_NONE;
         q.wp_high <= flash_host_pkg::CTRL_WP_RST;
      end
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   always_comb
   begin
      flash.addr = q.bus_addr;
      flash.dq_o = q.bus_data;
      flash.dq_oe = q.st == flash_host_pkg::S_WR_LOW
         || q.st == flash_host_pkg::S_WR_HIGH;
      flash.ce_n = !(q.st == flash_host_pkg::S_WR_LOW
         || q.st == flash_host_pkg::S_RD);
      flash.we_n = q.st != flash_host_pkg::S_WR_LOW;
      flash.oe_n = q.st != flash_host_pkg::S_RD;
      flash.reset_n = q.st != flash_host_pkg::S_RST_LOW;
      // dropping temp returns the pin to normal high and relocks
      flash.reset_elevated = q.temp && q.ready;
      flash.protect_accel_pin = q.wp_high | q.accel;
      flash.accel_high = q.accel;
   end

   assign reg_rdata = q.sw_rdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_reset_low_hold: assert property ($fell(flash.reset_n) |-> !flash.reset_n[*5])
      else $error("reset pin released too early");
   a_wake_no_read: assert property ($rose(flash.reset_n) |-> flash.oe_n[*2])
      else $error("read started inside wake time");
   a_powerup_low: assert property ($fell(rst) |-> !flash.reset_n)
      else $error("reset pin not low after power-up");
   a_float_in_reset: assert property (!flash.reset_n |-> !flash.dq_oe)
      else $error("data driven while reset low");
   a_bypass_first: assert property ((flash.accel_high && !flash.we_n
      && q.op == flash_host_pkg::OP_PROG && q.idx == 2'h0)
      |-> flash.dq_o == flash_host_pkg::PROG_DATA)
      else $error("bypass program not two-cycle");
   a_swreset_data: assert property ((!flash.we_n && q.op == flash_host_pkg::OP_SWRST)
      |-> flash.dq_o == flash_host_pkg::RESET_DATA)
      else $error("reset command word wrong");
   a_outer_refused: assert property ((cmd_wr && q.st == flash_host_pkg::S_IDLE
      && new_op == flash_host_pkg::OP_PROG && outer_lock)
      |=> q.refused && q.st == flash_host_pkg::S_IDLE)
      else $error("outer block program not refused");
   a_region_clear: assert property ($rose(flash.reset_n) |-> !q.in_region)
      else $error("region mode survived reset");
   a_elevated_high: assert property (flash.reset_elevated |-> flash.reset_n)
      else $error("elevated level while reset low");
   a_write_strobe: assert property ($fell(flash.we_n) |-> !flash.ce_n && flash.oe_n
      ##1 flash.we_n && flash.dq_oe)
      else $error("write pulse malformed");
   a_busy_refused: assert property ((cmd_wr && q.st != flash_host_pkg::S_IDLE)
      |=> q.refused)
      else $error("command accepted while busy");
   a_accel_pin_high: assert property (flash.accel_high |-> flash.protect_accel_pin)
      else $error("accelerate level without pin high");
   a_read_no_write: assert property (!flash.oe_n |-> flash.we_n && !flash.dq_oe)
      else $error("read overlaps a write");
   a_region_entry: assert property ((q.st == flash_host_pkg::S_WR_HIGH && q.last
      && q.op == flash_host_pkg::OP_ENTER) |=> q.in_region)
      else $error("region mode not entered");
   a_enter_word: assert property ((!flash.we_n && q.op == flash_host_pkg::OP_ENTER
      && q.last) |-> flash.dq_o == flash_host_pkg::ENTER_DATA)
      else $error("region entry word wrong");

   c_reset_done: cover property ($rose(flash.reset_n) ##2 q.ready);
   c_program: cover property (q.op == flash_host_pkg::OP_PROG && q.last
      && q.st == flash_host_pkg::S_WR_HIGH);
   c_region: cover property ($rose(q.in_region));
   // a refusal is a normal answer, so make sure the bench provokes one
   c_refusal: cover property ($rose(q.refused));
   c_read: cover property (q.st == flash_host_pkg::S_RD ##1 q.st == flash_host_pkg::S_RD);
endmodule : flash_protect_host
`default_nettype wire

// ===== sim/flash_dev_model.sv
// behavioural flash device answering the protection host
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter logic [16:0] PROT_GROUPS = 17'h00009,
   parameter logic LOCK_IND = 1'b0
) (
   input wire logic clk,
   input wire flash_host_pkg::pins_t pins,
   input wire logic [15:0] dq,
   output logic [15:0] dev_dq,
   output logic dev_oe
);
   // ----
   // array, region and command state
   // ----
   logic [15:0] mem [logic [19:0]];
   logic [15:0] sec [logic [19:0]];
   logic [15:0] val;
   logic region;
   int step;
   int nxt;
   realtime t_rise;

   function automatic int grp(input logic [19:0] a);
      if (a[19:15] == 5'h00)
         return int'(a[14:12]);
      if (a[19:17] == 3'h0)
         return 8;
      if (a[19:17] != 3'h7)
         return 8 + int'(a[19:17]);
      return (a[16:15] == 2'h3) ? 16 : 15;
   endfunction : grp

   initial
   begin
      sec[20'h00000] = {8'h00, LOCK_IND, 7'h00};
      region = 1'b0;
      step = 0;
      t_rise = 0;
   end

   always @(posedge pins.reset_n)
      t_rise = $realtime;

   task automatic do_prog(input logic [19:0] a, input logic [15:0] d);
      if (region && a < 20'h08000)
         sec[a] = d;
      else if ((pins.protect_accel_pin || grp(a) > 1)
         && (!PROT_GROUPS[grp(a)] || pins.reset_elevated || pins.accel_high))
         mem[a] = d;
   endtask : do_prog

   always @(posedge clk)
   begin
      if (!pins.reset_n)
      begin
         region = 1'b0;
         step = 0;
      end
      else if (!pins.ce_n && !pins.we_n && pins.oe_n)
      begin
         nxt = 0;
         if (step == 3)
            do_prog(pins.addr, dq);
         else if (step == 4)
            region = region && (dq != flash_host_pkg::EXIT2_DATA);
         else if (dq == flash_host_pkg::RESET_DATA)
            nxt = 0;
         else if (step == 0 && pins.accel_high && dq == flash_host_pkg::PROG_DATA)
            nxt = 3;
         else if (step == 0 && dq == flash_host_pkg::UNLOCK1_DATA)
            nxt = 1;
         else if (step == 1 && dq == flash_host_pkg::UNLOCK2_DATA)
            nxt = 2;
         else if (step == 2 && dq == flash_host_pkg::PROG_DATA)
            nxt = 3;
         else if (step == 2 && dq == flash_host_pkg::EXIT_DATA)
            nxt = 4;
         else if (step == 2 && dq == flash_host_pkg::ENTER_DATA)
            region = 1'b1;
         step = nxt;
      end
   end

   // outputs garbage until the wake-up time has run out
   always @(clk or pins)
   begin
      if (region && pins.addr < 20'h08000)
         val = sec.exists(pins.addr) ? sec[pins.addr] : 16'hFFFF;
      else
         val = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
      dev_oe = pins.reset_n && !pins.ce_n && !pins.oe_n;
      dev_dq = ($realtime - t_rise >= 200.0) ? val : ~val;
   end
endmodule : flash_dev_model
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the flash protection host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] rd;
   logic [15:0] dq_w;
   logic [15:0] dq_last = 16'h0;
   logic [15:0] dev_dq;
   logic dev_oe;
   flash_host_pkg::pins_t flash;
   int error_cnt = 0;
   int n_compared = 0;
   int low_cnt = 0;
   int wcnt = 0;

   // ----
   // wiring, clock and pin monitor
   // ----
   // undriven bus toggles so a stale value never reads as good
   assign dq_w = flash.dq_oe ? flash.dq_o : (dev_oe ? dev_dq : ~dq_last);
   always @(posedge clk)
      dq_last <= dq_w;

   flash_protect_host DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .dq_i(dq_w), .flash(flash));
   flash_dev_model model (.clk(clk), .pins(flash), .dq(dq_w), .dev_dq(dev_dq),
      .dev_oe(dev_oe));

   initial
   begin
      forever #50 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   always @(posedge clk)
   begin
      if (!flash.we_n && !flash.ce_n)
         wcnt++;
      if (!rst && !flash.reset_n)
      begin
         low_cnt++;
         check("dq_oe in reset", flash.dq_oe, 1'b0);
      end
      else if (!rst && low_cnt != 0)
      begin
         check("reset low cycles", low_cnt >= 5, 1'b1);
         low_cnt = 0;
      end
   end

   // ----
   // bus tasks
   // ----
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rdr

   task automatic cmd(input flash_host_pkg::op_t op);
      wr(flash_host_pkg::CMD_OFS, 32'(op));
      repeat (20)
      begin
         rdr(flash_host_pkg::STATUS_OFS);
         if (rd[0] === 1'b0)
            break;
      end
      check("busy", rd[0], 1'b0);
   endtask : cmd

   task automatic fread(input logic [19:0] a);
      wr(flash_host_pkg::ADDR_OFS, 32'(a));
      cmd(flash_host_pkg::OP_READ);
      rdr(flash_host_pkg::RDATA_OFS);
   endtask : fread

   task automatic prog(input logic [19:0] a, input logic [15:0] d);
      wr(flash_host_pkg::ADDR_OFS, 32'(a));
      wr(flash_host_pkg::WDATA_OFS, 32'(d));
      wcnt = 0;
      cmd(flash_host_pkg::OP_PROG);
   endtask : prog

   // ----
   // scenarios
   // ----
   task automatic t_reset;
      repeat (20)
      begin
         rdr(8'h10);
         if (rd[3] === 1'b1)
            break;
      end
      check("ready", rd[3], 1'b1);
      rdr(8'h3C);
      check("unmapped", rd, 32'h0);
      fread(20'h00100);
      check("erased", rd, 32'h0000FFFF);
   endtask : t_reset

   task automatic t_groups;
      logic [19:0] a [9] = '{20'h00000, 20'h01000, 20'h07FFF, 20'h08000, 20'h1FFFF,
         20'h20000, 20'hDFFFF, 20'hE0000, 20'hF8000};
      int g [9] = '{0, 1, 7, 8, 8, 9, 14, 15, 16};
      for (int i = 0; i < 9; i++)
      begin
         wr(8'h08, 32'(a[i]));
         rdr(8'h10);
         check("group", 32'(rd[8:4]), 32'(g[i]));
         check("outermost", rd[9], g[i] < 2);
      end
   endtask : t_groups

   task automatic t_protect;
      wr(8'h00, 32'h1);
      prog(20'h03000, 16'h1234);
      fread(20'h03000);
      check("locked group", rd, 32'h0000FFFF);
      wr(8'h00, 32'h5);
      prog(20'h03000, 16'h1234);
      fread(20'h03000);
      check("temp unprotect", rd, 32'h00001234);
      wr(8'h00, 32'h1);
      prog(20'h03000, 16'h0000);
      fread(20'h03000);
      check("relocked", rd, 32'h00001234);
   endtask : t_protect

   task automatic t_outer;
      wr(8'h00, 32'h0);
      prog(20'h01000, 16'hA5A5);
      rdr(8'h10);
      check("refused", rd[1], 1'b1);
      wr(8'h10, 32'h2);
      rdr(8'h10);
      check("refused cleared", rd[1], 1'b0);
      wr(8'h00, 32'h4);
      prog(20'h01000, 16'hA5A5);
      rdr(8'h10);
      check("refused in temp", rd[1], 1'b1);
      fread(20'h01000);
      check("outer kept", rd, 32'h0000FFFF);
      wr(8'h10, 32'h2);
      wr(8'h00, 32'h1);
      prog(20'h01000, 16'hA5A5);
      check("four cycles", wcnt, 32'd4);
      fread(20'h01000);
      check("outer open", rd, 32'h0000A5A5);
      prog(20'h00000, 16'h5A5A);
      fread(20'h00000);
      check("outer group lock", rd, 32'h0000FFFF);
      wr(8'h00, 32'h2);
      prog(20'h00010, 16'h1111);
      check("two cycles", wcnt, 32'd2);
      fread(20'h00010);
      check("accel program", rd, 32'h00001111);
      wr(8'h00, 32'h9);
      prog(20'h04000, 16'h3333);
      check("bypass cycles", wcnt, 32'd2);
      wr(8'h00, 32'h1);
   endtask : t_outer

   task automatic t_region;
      cmd(flash_host_pkg::OP_ENTER);
      rdr(8'h10);
      check("in region", rd[2], 1'b1);
      fread(20'h00000);
      check("lock bit", rd[7], 1'b0);
      fread(20'h00010);
      check("region view", rd, 32'h0000FFFF);
      prog(20'h00020, 16'hBEEF);
      fread(20'h00020);
      check("region write", rd, 32'h0000BEEF);
      prog(20'h08000, 16'h2222);
      cmd(flash_host_pkg::OP_EXIT);
      rdr(8'h10);
      check("left region", rd[2], 1'b0);
      fread(20'h00010);
      check("main back", rd, 32'h00001111);
      fread(20'h08000);
      check("region end", rd, 32'h00002222);
      cmd(flash_host_pkg::OP_ENTER);
      cmd(flash_host_pkg::OP_HWRST);
      rdr(8'h10);
      check("reset exits", rd[2], 1'b0);
      fread(20'h00010);
      check("read after wake", rd, 32'h00001111);
   endtask : t_region

   task automatic t_swrst;
      wcnt = 0;
      cmd(flash_host_pkg::OP_SWRST);
      check("one cycle", wcnt, 32'd1);
      rdr(8'h10);
      check("idle", rd[1:0], 2'h0);
      fread(20'h00010);
      check("read mode", rd, 32'h00001111);
      wcnt = 0;
      wr(flash_host_pkg::CMD_OFS, 32'(flash_host_pkg::OP_SWRST));
      cmd(flash_host_pkg::OP_SWRST);
      rdr(flash_host_pkg::STATUS_OFS);
      check("busy refusal", rd[1], 1'b1);
      check("one reset", wcnt, 32'd1);
   endtask : t_swrst

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   initial
   begin
      #3000000;
      error_cnt++;
      close_out;
   end

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_groups;
      t_protect;
      t_outer;
      t_region;
      t_swrst;
      close_out;
   end
endmodule : tb_top
`default_nettype wire
